// ===== core/redriver_ctrl.sv
// Purpose: path mux, equalization and link power-state control
// Assumes: SYS_RST_I is the internal power-good style reset source
// Notes:   detector inputs and straps are asynchronous and synchronised
//
// How it works
// - flip from pin, or register in i2c mode
// - enable low disables path whatever flip
// - flip 0 uses port one, 1 port two
// - gain code is high code then low code
// - each lane own register gain; port lanes share one strap gain
// - enabled path always in one of four states
// - disconnect to U0 once both terminations seen
// - U0 redrives; both idle moves to U1
// - U1 keeps termination and transmit common mode
// - U2/U3 polls detection; missing termination disconnects
// - U2/U3 valid LFPS moves straight to U0
// - U2/U3 keeps termination, drops common mode
// - power good within 500 us of supply
// - address low bits from host gain low strap
// - straps sampled after release, bias off later
// - equalization off while LFPS is received
`timescale 1ns/10ps
module redriver_ctrl
    import redriver_pkg::*;
(
    input  wire logic       CLK_I,
    input  wire logic       SYS_RST_I,
    input  wire logic       LINK_CLK_I,
    input  wire logic       USB_PATH_ENABLE_PIN_I,
    input  wire logic       PATH_FLIP_PIN_I,
    input  wire logic [1:0] BUS_MODE_STRAP_I,
    input  wire logic [1:0] PORT_GAIN_STRAP_HI_I,
    input  wire logic [1:0] PORT_GAIN_STRAP_LO_I,
    input  wire logic [1:0] HOST_GAIN_STRAP_HI_I,
    input  wire logic [1:0] HOST_GAIN_STRAP_LO_I,
    input  wire logic [1:0] ADDR_STRAP_HI_I,
    input  wire logic       USB_PATH_ENABLE_BIT_I,
    input  wire logic       PATH_FLIP_BIT_I,
    input  wire logic [3:0] PORT_ONE_GAIN_REG_I,
    input  wire logic [3:0] PORT_TWO_GAIN_REG_I,
    input  wire logic [3:0] HOST_TX_GAIN_REG_I,
    input  wire logic       TERM_UP_I,
    input  wire logic       TERM_DN_I,
    input  wire logic       IDLE_UP_I,
    input  wire logic       IDLE_DN_I,
    input  wire logic       LFPS_I,
    output logic            POWER_GOOD_O,
    output logic            STRAP_BIAS_EN_O,
    output logic            I2C_MODE_O,
    output logic [6:0]      I2C_ADDR_O,
    output logic            PATH_EN_O,
    output logic            PATH_SEL_O,
    output logic            EQ_EN_O,
    output logic [3:0]      PORT_ONE_EQ_O,
    output logic [3:0]      PORT_TWO_EQ_O,
    output logic [3:0]      HOST_EQ_O,
    output logic [3:0]      LINK_STATE_O,
    output logic            TERM_EN_O,
    output logic            TX_CM_EN_O,
    output logic            REDRIVE_EN_O,
    output logic            RX_DETECT_O
);

    // ==========================================================
    // decode functions
    function automatic logic [4:0] addr_hi_bits(input logic [1:0] lvl);
        case (lvl)
            LVL_0:   addr_hi_bits = ADDR_HI_0;
            LVL_R:   addr_hi_bits = ADDR_HI_R;
            LVL_F:   addr_hi_bits = ADDR_HI_F;
            default: addr_hi_bits = ADDR_HI_1;
        endcase
    endfunction

    function automatic logic [3:0] gain_pick(
        input logic       i2c,
        input logic [3:0] strap_code,
        input logic [3:0] reg_code
    );
        gain_pick = i2c ? reg_code : strap_code;
    endfunction

    // ==========================================================
    // pin synchronisers, system domain
    localparam int PIN_W = 14;
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_s;

    assign pin_raw = {USB_PATH_ENABLE_PIN_I, PATH_FLIP_PIN_I,
                      BUS_MODE_STRAP_I, PORT_GAIN_STRAP_HI_I,
                      PORT_GAIN_STRAP_LO_I, HOST_GAIN_STRAP_HI_I,
                      HOST_GAIN_STRAP_LO_I, ADDR_STRAP_HI_I};

    sync_2ff #(.W(PIN_W)) u_pin_sync (
        .clk_i (CLK_I),
        .rst_i (SYS_RST_I),
        .d_i   (pin_raw),
        .q_o   (pin_s)
    );

    logic       en_pin_s, flip_pin_s;
    logic [1:0] mode_s;
    logic [3:0] port_strap_s;
    logic [3:0] host_strap_s;
    logic [1:0] addr_hi_s;

    assign en_pin_s     = pin_s[13];
    assign flip_pin_s   = pin_s[12];
    assign mode_s       = pin_s[11:10];
    assign port_strap_s = pin_s[9:6];
    assign host_strap_s = pin_s[5:2];
    assign addr_hi_s    = pin_s[1:0];

    // ==========================================================
    // strap sampling after reset release
    logic [CFG_CNT_W-1:0] cfg_cnt_ff;
    logic                 sampled_ff;
    logic                 bias_on_ff;
    logic                 pg_ff;

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            cfg_cnt_ff <= '0;
        end else if (bias_on_ff) begin
            cfg_cnt_ff <= cfg_cnt_ff + CFG_CNT_W'(1);
        end
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            sampled_ff <= 1'b0;
            pg_ff      <= 1'b0;
            bias_on_ff <= 1'b1;
        end else begin
            if (cfg_cnt_ff == CFG_CNT_W'(STRAP_SAMPLE_CYC)) begin
                sampled_ff <= 1'b1;
                pg_ff      <= 1'b1;
            end
            if (cfg_cnt_ff == CFG_CNT_W'(BIAS_OFF_CYC)) begin
                bias_on_ff <= 1'b0;
            end
        end
    end

    // ==========================================================
    // latched configuration
    logic       i2c_mode_ff;
    logic [3:0] port_strap_ff;
    logic [3:0] host_strap_ff;
    logic [6:0] addr_ff;

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            i2c_mode_ff   <= 1'b0;
            port_strap_ff <= GAIN_RST;
            host_strap_ff <= GAIN_RST;
            addr_ff       <= ADDR_RST;
        end else if (!sampled_ff &&
                     cfg_cnt_ff == CFG_CNT_W'(STRAP_SAMPLE_CYC)) begin
            i2c_mode_ff   <= (mode_s != LVL_0);
            port_strap_ff <= port_strap_s;
            host_strap_ff <= host_strap_s;
            addr_ff       <= {addr_hi_bits(addr_hi_s),
                              host_strap_s[1:0]};
        end
    end

    // ==========================================================
    // path selection
    logic path_en, path_flip;
    logic path_en_ff;
    logic path_sel_ff;

    assign path_en   = i2c_mode_ff ? USB_PATH_ENABLE_BIT_I
                                   : en_pin_s;
    assign path_flip = i2c_mode_ff ? PATH_FLIP_BIT_I
                                   : flip_pin_s;

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            path_en_ff  <= 1'b0;
            path_sel_ff <= 1'b0;
        end else begin
            path_en_ff  <= path_en && pg_ff;
            path_sel_ff <= path_en && pg_ff && path_flip;
        end
    end

    // ==========================================================
    // equalization, gated by received LFPS
    logic       lfps_sys;
    logic       eq_en_ff;
    logic [3:0] port_one_eq_ff;
    logic [3:0] port_two_eq_ff;
    logic [3:0] host_eq_ff;

    sync_2ff #(.W(1)) u_lfps_sync (
        .clk_i (CLK_I),
        .rst_i (SYS_RST_I),
        .d_i   (LFPS_I),
        .q_o   (lfps_sys)
    );

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            eq_en_ff       <= 1'b0;
            port_one_eq_ff <= GAIN_RST;
            port_two_eq_ff <= GAIN_RST;
            host_eq_ff     <= GAIN_RST;
        end else begin
            eq_en_ff       <= pg_ff && !lfps_sys;
            port_one_eq_ff <= gain_pick(i2c_mode_ff, port_strap_ff,
                                        PORT_ONE_GAIN_REG_I);
            port_two_eq_ff <= gain_pick(i2c_mode_ff, port_strap_ff,
                                        PORT_TWO_GAIN_REG_I);
            host_eq_ff     <= gain_pick(i2c_mode_ff, host_strap_ff,
                                        HOST_TX_GAIN_REG_I);
        end
    end

    assign POWER_GOOD_O    = pg_ff;
    assign STRAP_BIAS_EN_O = bias_on_ff;
    assign I2C_MODE_O      = i2c_mode_ff;
    assign I2C_ADDR_O      = addr_ff;
    assign PATH_EN_O       = path_en_ff;
    assign PATH_SEL_O      = path_sel_ff;
    assign EQ_EN_O         = eq_en_ff;
    assign PORT_ONE_EQ_O   = port_one_eq_ff;
    assign PORT_TWO_EQ_O   = port_two_eq_ff;
    assign HOST_EQ_O       = host_eq_ff;

    // ==========================================================
    // link domain reset and detector synchronisers
    logic lrst_meta_ff;
    logic lrst_ff;

    always_ff @(posedge LINK_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            lrst_meta_ff <= 1'b1;
            lrst_ff      <= 1'b1;
        end else begin
            lrst_meta_ff <= 1'b0;
            lrst_ff      <= lrst_meta_ff;
        end
    end

    logic [5:0] det_s;

    sync_2ff #(.W(6)) u_det_sync (
        .clk_i (LINK_CLK_I),
        .rst_i (lrst_ff),
        .d_i   ({path_en_ff, TERM_UP_I, TERM_DN_I,
                 IDLE_UP_I, IDLE_DN_I, LFPS_I}),
        .q_o   (det_s)
    );

    logic l_en, l_term, l_idle, l_lfps;

    assign l_en   = det_s[5];
    assign l_term = det_s[4] && det_s[3];
    assign l_idle = det_s[2] && det_s[1];
    assign l_lfps = det_s[0];

    // ==========================================================
    // periodic receiver detection and U1 idle timers
    link_state_e            state_ff;
    link_state_e            nxt_state;
    logic [LINK_CNT_W-1:0]  det_cnt_ff;
    logic [LINK_CNT_W-1:0]  u1_cnt_ff;
    logic                   det_tick, u1_done;

    assign det_tick = (det_cnt_ff == LINK_CNT_W'(RX_DET_PERIOD_CYC - 1));
    assign u1_done  = (u1_cnt_ff == LINK_CNT_W'(U1_IDLE_CYC - 1));

    always_ff @(posedge LINK_CLK_I or posedge lrst_ff) begin
        if (lrst_ff) begin
            det_cnt_ff <= '0;
        end else if (det_tick ||
                     !(state_ff == ST_DISC || state_ff == ST_U23)) begin
            det_cnt_ff <= '0;
        end else begin
            det_cnt_ff <= det_cnt_ff + LINK_CNT_W'(1);
        end
    end

    always_ff @(posedge LINK_CLK_I or posedge lrst_ff) begin
        if (lrst_ff) begin
            u1_cnt_ff <= '0;
        end else if (state_ff != ST_U1 || u1_done) begin
            u1_cnt_ff <= '0;
        end else begin
            u1_cnt_ff <= u1_cnt_ff + LINK_CNT_W'(1);
        end
    end

    // ==========================================================
    // power-state machine
    always_comb begin
        nxt_state = state_ff;
        if (!l_en) begin
            nxt_state = ST_DISC;
        end else begin
            case (state_ff)
                ST_DISC: if (l_term) nxt_state = ST_U0;
                ST_U0:   if (l_idle) nxt_state = ST_U1;
                ST_U1: begin
                    if (l_lfps || !l_idle) nxt_state = ST_U0;
                    else if (u1_done) nxt_state = ST_U23;
                end
                ST_U23: begin
                    if (!l_term) nxt_state = ST_DISC;
                    else if (l_lfps) nxt_state = ST_U0;
                end
                default: nxt_state = ST_DISC;
            endcase
        end
    end

    always_ff @(posedge LINK_CLK_I or posedge lrst_ff) begin
        if (lrst_ff) begin
            state_ff <= ST_DISC;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ==========================================================
    // link-side outputs registered from the next state; detect pulse from the poll timer
    logic [3:0] lstate_ff;
    logic       term_en_ff;
    logic       tx_cm_ff;
    logic       redrive_ff;
    logic       rx_det_ff;

    always_ff @(posedge LINK_CLK_I or posedge lrst_ff) begin
        if (lrst_ff) begin
            lstate_ff  <= ST_DISC;
            term_en_ff <= 1'b0;
            tx_cm_ff   <= 1'b0;
            redrive_ff <= 1'b0;
            rx_det_ff  <= 1'b0;
        end else begin
            lstate_ff  <= nxt_state;
            term_en_ff <= (nxt_state != ST_DISC);
            tx_cm_ff   <= (nxt_state == ST_U0) ||
                          (nxt_state == ST_U1);
            redrive_ff <= (nxt_state == ST_U0);
            rx_det_ff  <= det_tick && l_en;
        end
    end

    assign LINK_STATE_O = lstate_ff;
    assign TERM_EN_O    = term_en_ff;
    assign TX_CM_EN_O   = tx_cm_ff;
    assign REDRIVE_EN_O = redrive_ff;
    assign RX_DETECT_O  = rx_det_ff;

endmodule // redriver_ctrl

// ===== core/sync_2ff.sv
// Purpose: two flip-flop level synchroniser, W bits wide
// Assumes: each bit is an independent level
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
module sync_2ff #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // ==========================================================
    // two stages
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= d_i;
            sync_ff <= meta_ff;
        end
    end

    assign q_o = sync_ff;

endmodule // sync_2ff

// ===== include/redriver_pkg.sv
// Purpose: shared constants for the redriver mode control block
// Assumes: strap levels arrive as 2-bit codes 0=00 R=01 F=10 1=11
// Notes:   system times kept in us, cycle counts derived; link timing set in cycles
package redriver_pkg;

    // ==========================================================
    // strap level codes
    localparam logic [1:0] LVL_0 = 2'h0;
    localparam logic [1:0] LVL_R = 2'h1;
    localparam logic [1:0] LVL_F = 2'h2;
    localparam logic [1:0] LVL_1 = 2'h3;

    // ==========================================================
    // address bits 6:2 for each high address strap level
    localparam logic [4:0] ADDR_HI_0 = 5'h11;
    localparam logic [4:0] ADDR_HI_R = 5'h08;
    localparam logic [4:0] ADDR_HI_F = 5'h04;
    localparam logic [4:0] ADDR_HI_1 = 5'h03;

    // ==========================================================
    // timing
    localparam int CLK_MHZ          = 125;
    localparam int POWER_GOOD_US    = 500;
    localparam int STRAP_SETUP_US   = 50;
    localparam int STRAP_HOLD_US    = 10;
    localparam int SYNC_STAGES      = 2;
    // strap sample taken once the pin synchronisers hold post-reset data
    localparam int STRAP_SAMPLE_CYC = SYNC_STAGES + 1;
    // hold interval converted to cycles with no rounding
    localparam int STRAP_HOLD_CYC   = (STRAP_HOLD_US * CLK_MHZ + 0);
    localparam int BIAS_OFF_CYC     = STRAP_SAMPLE_CYC + STRAP_HOLD_CYC;
    localparam int CFG_CNT_W        = 12;

    // link-domain timing, in link clock cycles
    localparam int RX_DET_PERIOD_CYC = 100;
    localparam int U1_IDLE_CYC       = 64;
    localparam int LINK_CNT_W        = 8;

    // ==========================================================
    // link power states, one-hot
    typedef enum logic [3:0] {
        ST_DISC = 4'h1,
        ST_U0   = 4'h2,
        ST_U1   = 4'h4,
        ST_U23  = 4'h8
    } link_state_e;

    // reset values
    localparam logic [3:0] GAIN_RST = 4'h0;
    localparam logic [6:0] ADDR_RST = 7'h00;

endpackage

// ===== verification/redriver_ctrl_properties.sv
// Purpose: concurrent checks on the redriver_ctrl ports
// Assumes: bound into every redriver_ctrl instance
// Notes:   link-state checks run on LINK_CLK_I
`timescale 1ns/10ps
module redriver_ctrl_checker (
    input wire logic       CLK_I,
    input wire logic       SYS_RST_I,
    input wire logic       LINK_CLK_I,
    input wire logic       USB_PATH_ENABLE_BIT_I,
    input wire logic       PATH_FLIP_BIT_I,
    input wire logic [1:0] HOST_GAIN_STRAP_LO_I,
    input wire logic       TERM_UP_I,
    input wire logic       TERM_DN_I,
    input wire logic       IDLE_UP_I,
    input wire logic       IDLE_DN_I,
    input wire logic       LFPS_I,
    input wire logic       POWER_GOOD_O,
    input wire logic       I2C_MODE_O,
    input wire logic [6:0] I2C_ADDR_O,
    input wire logic       PATH_EN_O,
    input wire logic       PATH_SEL_O,
    input wire logic       EQ_EN_O,
    input wire logic [3:0] LINK_STATE_O,
    input wire logic       TERM_EN_O,
    input wire logic       TX_CM_EN_O,
    input wire logic       REDRIVE_EN_O
);
    // ==========================================================
    // system clock domain
    a_power_good: assert property (@(posedge CLK_I)
        disable iff (SYS_RST_I) $fell(SYS_RST_I) |-> ##[1:8] POWER_GOOD_O)
        else $error("power good late after reset");
    a_path_enable: assert property (@(posedge CLK_I)
        disable iff (SYS_RST_I) I2C_MODE_O && $past(POWER_GOOD_O)
        |-> PATH_EN_O == $past(USB_PATH_ENABLE_BIT_I))
        else $error("path enable does not follow bit");
    a_path_select: assert property (@(posedge CLK_I)
        disable iff (SYS_RST_I) I2C_MODE_O && $past(POWER_GOOD_O) |->
        PATH_SEL_O == ($past(USB_PATH_ENABLE_BIT_I) & $past(PATH_FLIP_BIT_I)))
        else $error("path select does not follow flip bit");
    a_addr_low: assert property (@(posedge CLK_I)
        disable iff (SYS_RST_I)
        POWER_GOOD_O |-> I2C_ADDR_O[1:0] == HOST_GAIN_STRAP_LO_I)
        else $error("address low bits differ from strap");
    a_eq_lfps: assert property (@(posedge CLK_I)
        disable iff (SYS_RST_I) (POWER_GOOD_O && LFPS_I)[*4] |-> !EQ_EN_O)
        else $error("equalization on during lfps");
    // ==========================================================
    // link clock domain
    a_state_onehot: assert property (@(posedge LINK_CLK_I)
        disable iff (SYS_RST_I) $onehot(LINK_STATE_O))
        else $error("link state not one of four");
    a_disc_exit: assert property (@(posedge LINK_CLK_I)
        disable iff (SYS_RST_I) (PATH_EN_O && TERM_UP_I && TERM_DN_I)[*6]
        |-> LINK_STATE_O != 4'h1)
        else $error("disconnect kept with both terminations");
    a_u0_idle: assert property (@(posedge LINK_CLK_I)
        disable iff (SYS_RST_I) LINK_STATE_O == 4'h2 ##0
        (IDLE_UP_I && IDLE_DN_I && !LFPS_I)[*4] |=> LINK_STATE_O != 4'h2)
        else $error("u0 kept with both ports idle");
    a_u0_redrive: assert property (@(posedge LINK_CLK_I)
        disable iff (SYS_RST_I) LINK_STATE_O == 4'h2 |-> REDRIVE_EN_O)
        else $error("u0 without redrive");
    a_u1_lines: assert property (@(posedge LINK_CLK_I)
        disable iff (SYS_RST_I)
        LINK_STATE_O == 4'h4 |-> TERM_EN_O && TX_CM_EN_O)
        else $error("u1 lost termination or common mode");
    a_u23_term: assert property (@(posedge LINK_CLK_I)
        disable iff (SYS_RST_I) LINK_STATE_O == 4'h8 ##0
        (!TERM_UP_I || !TERM_DN_I)[*4] |=> LINK_STATE_O == 4'h1)
        else $error("u2u3 kept without termination");
    a_u23_lines: assert property (@(posedge LINK_CLK_I)
        disable iff (SYS_RST_I)
        LINK_STATE_O == 4'h8 |-> TERM_EN_O && !TX_CM_EN_O)
        else $error("u2u3 termination or common mode wrong");
endmodule // redriver_ctrl_checker

bind redriver_ctrl redriver_ctrl_checker u_chk (.*);

// ===== verification/strap_board.sv
// Purpose: board strap resistors on the four-level strap pins
// Assumes: {mode, port hi, port lo, host hi, host lo, addr hi}
// Notes:   new settings taken only while reset is high
`timescale 1ns/10ps
module strap_board (
    input  wire logic        rst_i,
    input  wire logic [11:0] want_i,
    output logic      [11:0] strap_o
);
    // ==========================================================
    // straps held from before release until the next reset
    always_latch begin
        if (rst_i) begin
            strap_o <= want_i;
        end
    end
endmodule // strap_board

// ===== verification/tb_top.sv
// Purpose: self-checking bench for redriver_ctrl
// Assumes: straps come from strap_board, set during reset
// Notes:   one task per scenario, inputs driven on falling CLK_I
`timescale 1ns/10ps
`define CHK(g, e, m) begin compares++; if ((g) !== (e)) begin \
    n_fail++; $display("mismatch %0t %s", $time, m); end end
module tb_top
    import redriver_pkg::*;
();
    logic        clk, link_clk, rst, en_pin, flip_pin, en_bit, flip_bit;
    logic        term_up, term_dn, idle_up, idle_dn, lfps, pg, bias, i2c;
    logic        pen, psel, eqen, term_en, cm_en, rd_en, rxdet;
    logic [3:0]  g1, g2, gh, eq1, eq2, eqh, lstate;
    logic [11:0] want, straps;
    logic [6:0]  addr;
    int          n_fail, compares;

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #15 link_clk = ~link_clk;
    end

    strap_board board (.rst_i(rst), .want_i(want), .strap_o(straps));
    redriver_ctrl dut (
        .CLK_I(clk), .SYS_RST_I(rst), .LINK_CLK_I(link_clk),
        .USB_PATH_ENABLE_PIN_I(en_pin), .PATH_FLIP_PIN_I(flip_pin),
        .BUS_MODE_STRAP_I(straps[11:10]), .PORT_GAIN_STRAP_HI_I(straps[9:8]),
        .PORT_GAIN_STRAP_LO_I(straps[7:6]), .HOST_GAIN_STRAP_HI_I(straps[5:4]),
        .HOST_GAIN_STRAP_LO_I(straps[3:2]), .ADDR_STRAP_HI_I(straps[1:0]),
        .USB_PATH_ENABLE_BIT_I(en_bit), .PATH_FLIP_BIT_I(flip_bit),
        .PORT_ONE_GAIN_REG_I(g1), .PORT_TWO_GAIN_REG_I(g2),
        .HOST_TX_GAIN_REG_I(gh), .TERM_UP_I(term_up), .TERM_DN_I(term_dn),
        .IDLE_UP_I(idle_up), .IDLE_DN_I(idle_dn), .LFPS_I(lfps),
        .POWER_GOOD_O(pg), .STRAP_BIAS_EN_O(bias), .I2C_MODE_O(i2c),
        .I2C_ADDR_O(addr), .PATH_EN_O(pen), .PATH_SEL_O(psel),
        .EQ_EN_O(eqen), .PORT_ONE_EQ_O(eq1), .PORT_TWO_EQ_O(eq2),
        .HOST_EQ_O(eqh), .LINK_STATE_O(lstate), .TERM_EN_O(term_en),
        .TX_CM_EN_O(cm_en), .REDRIVE_EN_O(rd_en), .RX_DETECT_O(rxdet)
    );

    // ==========================================================
    // helpers
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic link_until(input logic [3:0] e, input int lim);
        int k;
        k = 0;
        while (lstate !== e && k < lim) begin
            @(posedge link_clk);
            #1;
            k++;
        end
        `CHK(lstate, e, "link state")
        @(negedge clk);
    endtask
    task automatic boot(input logic [11:0] cfg);
        int k;
        rst = 1'b1;
        want = cfg;
        cyc(8);
        rst = 1'b0;
        k = 0;
        while (pg !== 1'b1 && k < 12) begin
            cyc(1);
            k++;
        end
        `CHK(pg, 1'b1, "power good late")
        cyc(2);
    endtask
    function automatic logic [4:0] amap(input logic [1:0] l);
        return (l == 2'h0) ? 5'h11 : (l == 2'h1) ? 5'h08 :
               (l == 2'h2) ? 5'h04 : 5'h03;
    endfunction
    task automatic conclude();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_straps();
        logic [1:0] a, b;
        for (int i = 0; i < 16; i++) begin
            a = i[3:2];
            b = i[1:0];
            boot({LVL_0, a, b, b, a, b});
            `CHK(i2c, 1'b0, "bus mode")
            `CHK({eq1, eq2}, {a, b, a, b}, "port gain")
            `CHK(eqh, {b, a}, "host gain")
            `CHK(addr[1:0], a, "addr low")
            `CHK(addr[6:2], amap(b), "addr high")
        end
        $display("test straps done");
    endtask
    task automatic t_bias();
        int k;
        k = 0;
        boot({LVL_0, 10'h000});
        while (bias === 1'b1 && k < 1400) begin
            cyc(1);
            k++;
        end
        `CHK(k > 1230 && k < 1260, 1'b1, "bias hold")
        $display("test bias done");
    endtask
    task automatic t_path(input logic mode);
        logic e, f;
        for (int i = 0; i < 4; i++) begin
            e = i[1];
            f = i[0];
            {en_pin, flip_pin} = mode ? {~e, ~f} : {e, f};
            {en_bit, flip_bit} = mode ? {e, f} : {~e, ~f};
            cyc(5);
            `CHK(pen, e, "path enable")
            `CHK(psel, e & f, "path select")
        end
        $display("test path done");
    endtask
    task automatic t_reg();
        logic [3:0] v;
        boot({LVL_F, 10'h155});
        `CHK(i2c, 1'b1, "bus mode")
        t_path(1'b1);
        for (int k = 0; k < 16; k += 5) begin
            v = k[3:0];
            g1 = v;
            g2 = ~v;
            gh = v ^ 4'h9;
            cyc(2);
            `CHK({eq1, eq2, eqh}, {v, ~v, v ^ 4'h9}, "reg gain")
        end
        $display("test registers done");
    endtask
    task automatic t_lfps();
        lfps = 1'b1;
        cyc(5);
        `CHK(eqen, 1'b0, "eq during lfps")
        lfps = 1'b0;
        cyc(5);
        `CHK(eqen, 1'b1, "eq after lfps")
        $display("test lfps done");
    endtask
    task automatic t_link();
        int k;
        term_up = 1'b1;
        repeat (10) @(posedge link_clk);
        #1;
        link_until(ST_DISC, 0);
        term_dn = 1'b1;
        link_until(ST_U0, 6);
        `CHK({rd_en, term_en, cm_en}, 3'h7, "u0 lines")
        {idle_up, idle_dn} = 2'h3;
        link_until(ST_U1, 6);
        `CHK({rd_en, term_en, cm_en}, 3'h3, "u1 lines")
        link_until(ST_U23, 80);
        `CHK({rd_en, term_en, cm_en}, 3'h2, "u23 lines")
        k = 0;
        while (rxdet !== 1'b1 && k < 110) begin
            @(posedge link_clk);
            #1;
            k++;
        end
        `CHK(rxdet, 1'b1, "detect poll")
        @(negedge clk);
        {idle_up, idle_dn, lfps} = 3'h1;
        link_until(ST_U0, 6);
        {idle_up, idle_dn, lfps} = 3'h6;
        link_until(ST_U1, 6);
        idle_dn = 1'b0;
        link_until(ST_U0, 6);
        idle_dn = 1'b1;
        link_until(ST_U23, 80);
        term_dn = 1'b0;
        link_until(ST_DISC, 6);
        {idle_up, idle_dn, term_dn} = 3'h1;
        link_until(ST_U0, 6);
        en_bit = 1'b0;
        link_until(ST_DISC, 12);
        $display("test link done");
    endtask

    initial begin
        {rst, en_pin, flip_pin, en_bit, flip_bit, lfps} = 6'h20;
        {term_up, term_dn, idle_up, idle_dn} = 4'h0;
        {g1, g2, gh} = 12'h000;
        want = 12'h000;
        n_fail = 0;
        compares = 0;
        cyc(8);
        t_straps();
        t_bias();
        t_path(1'b0);
        t_reg();
        t_lfps();
        t_link();
        conclude();
    end
    initial begin
        #200000;
        n_fail++;
        $display("mismatch %0t watchdog", $time);
        conclude();
    end
endmodule // tb_top
